// ===== hw/hpb_pkg.sv
// Functional notes
// - The host drives a 15-bit address that picks the register or buffer word each access targets, and the port decodes it.
// - The 8-bit data bus is two-way: the port drives it on reads and takes it in on writes.
// - In the separate-strobe style the shared write/direction pin is an active-low write strobe.
// - In the separate-strobe style the data input buffers are enabled while the write strobe is low.
// - In the separate-strobe style the data are stored on the rising edge of the write strobe.
// - In the data-strobe style the shared pin gives the transfer direction instead of a write strobe.
// - A 3-bit style select picks the bus style: 000 separate strobes, 001 data strobe, the other codes synchronous styles.
// - In the separate-strobe style the port drives read data while the read strobe is low and floats the bus after.
// - In the synchronous styles all pins are sampled and the data bus and acknowledge are updated on the clock.
`default_nettype none
package hpb_pkg;
  localparam int ADDR_W    = 15;
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 32768;
  localparam logic [DATA_W-1:0] MEM_RESET = 8'h00;
  localparam logic [2:0] STYLE_SEP_STROBE  = 3'h0;
  localparam logic [2:0] STYLE_DATA_STROBE = 3'h1;
  typedef enum logic [1:0] {
    HPB_IDLE  = 2'b00,
    HPB_READ  = 2'b01,
    HPB_WRITE = 2'b10,
    HPB_DONE  = 2'b11
  } hpb_state_t;
endpackage
`default_nettype wire

// ===== hw/hpb_mem_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hpb_mem_if;
  logic                      wr_en;
  logic [hpb_pkg::ADDR_W-1:0] addr;
  logic [hpb_pkg::DATA_W-1:0] wr_data;
  logic [hpb_pkg::DATA_W-1:0] rd_data;
  modport ctrl (output wr_en, output addr, output wr_data, input rd_data);
  modport mem  (input wr_en, input addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// ===== hw/hpb_store.sv
`timescale 1ns/100ps
`default_nettype none
module hpb_store (
  input  wire logic i_ref_clk,
  hpb_mem_if.mem    port
);
  logic [hpb_pkg::DATA_W-1:0] words [hpb_pkg::MEM_DEPTH];

  // no reset on the array: it maps to block ram; read data are registered
  always_ff @(posedge i_ref_clk) begin
    if (port.wr_en) begin
      words[port.addr] <= port.wr_data;
    end
    port.rd_data <= words[port.addr];
  end
endmodule
`default_nettype wire

// ===== hw/hpb_port.sv
`timescale 1ns/100ps
`default_nettype none
module hpb_port (
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_srst,
  input  wire logic [2:0]                  i_bus_style_select,
  input  wire logic                        i_chip_select_n,
  input  wire logic [hpb_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [hpb_pkg::DATA_W-1:0]  i_data,
  output logic      [hpb_pkg::DATA_W-1:0]  o_data,
  output logic                             o_data_oe,
  output logic                             o_data_buffer_enable,
  input  wire logic                        i_write_or_direction_pin,
  input  wire logic                        i_read_or_datastrobe_pin,
  output logic                             o_access_ack_out
);
  hpb_mem_if mem_bus ();
  hpb_store u_store (
    .i_ref_clk (i_ref_clk),
    .port      (mem_bus)
  );

  ////////////////////////////////////////////////////////////////////////
  // style decode and strobe history
  logic       sep_style;
  logic       ds_style;
  logic       sync_style;
  logic       selected;
  logic       wr_n_d;
  logic       rd_n_d;
  logic       wr_rise;
  logic       ds_fall;
  logic       ds_rise;
  logic       rd_fall;
  logic       rd_rise;

  assign sep_style  = (i_bus_style_select == hpb_pkg::STYLE_SEP_STROBE);
  assign ds_style   = (i_bus_style_select == hpb_pkg::STYLE_DATA_STROBE);
  // every other code, the undefined 110 included, runs the clocked handshake
  assign sync_style = !sep_style && !ds_style;
  assign selected   = !i_chip_select_n;

  // history resets to the idle level, so leaving reset with the pins idle is never seen as an edge; a strobe held low shows as a fall
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      wr_n_d <= 1'b1;
    end else begin
      wr_n_d <= i_write_or_direction_pin;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rd_n_d <= 1'b1;
    end else begin
      rd_n_d <= i_read_or_datastrobe_pin;
    end
  end

  assign wr_rise = !wr_n_d && i_write_or_direction_pin;
  assign rd_fall = rd_n_d && !i_read_or_datastrobe_pin;
  assign rd_rise = !rd_n_d && i_read_or_datastrobe_pin;
  assign ds_fall = rd_fall;
  assign ds_rise = rd_rise;

  ////////////////////////////////////////////////////////////////////////
  // access sequencer
  hpb_pkg::hpb_state_t        state;
  logic [hpb_pkg::ADDR_W-1:0] lat_addr;
  logic [hpb_pkg::DATA_W-1:0] lat_data;
  logic                       read_phase;
  logic                       do_write;
  logic                       sync_wr;
  logic                       sync_rd;
  logic                       sync_is_read;
  // per-style pieces of the write commit and the read drive
  logic                       sep_commit;
  logic                       ds_commit;
  logic                       sync_commit;
  logic                       sep_drive;
  logic                       ds_drive;
  logic                       sync_drive;

  // synchronous styles: direction high with a low strobe means write, direction low means read
  assign sync_wr = sync_style && selected && !i_read_or_datastrobe_pin && i_write_or_direction_pin
                   && state == hpb_pkg::HPB_IDLE;
  assign sync_rd = sync_style && selected && !i_read_or_datastrobe_pin && !i_write_or_direction_pin
                   && state == hpb_pkg::HPB_IDLE;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state <= hpb_pkg::HPB_IDLE;
    end else begin
      case (state)
        hpb_pkg::HPB_IDLE: begin
          // only idle takes an access, so a strobe held low cannot start a second one
          if (sync_rd) begin
            state <= hpb_pkg::HPB_READ;
          end else if (sync_wr) begin
            state <= hpb_pkg::HPB_WRITE;
          end
        end
        hpb_pkg::HPB_READ: begin
          state <= hpb_pkg::HPB_DONE;
        end
        hpb_pkg::HPB_WRITE: begin
          state <= hpb_pkg::HPB_DONE;
        end
        hpb_pkg::HPB_DONE: begin
          // hold the acknowledge until the host drops its strobe
          if (i_read_or_datastrobe_pin || !selected) begin
            state <= hpb_pkg::HPB_IDLE;
          end
        end
        default: begin
          state <= hpb_pkg::HPB_IDLE;
        end
      endcase
    end
  end

  // direction is fixed when the access is taken; the pin may move while the strobe is held
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sync_is_read <= 1'b0;
    end else if (sync_rd) begin
      sync_is_read <= 1'b1;
    end else if (sync_wr) begin
      sync_is_read <= 1'b0;
    end
  end

  // address latched while the host holds it steady
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      lat_addr <= '0;
    end else if (selected && (state == hpb_pkg::HPB_IDLE)) begin
      lat_addr <= i_addr;
    end
  end

  // write data are taken a clock before the commit edge, while the host still drives them
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      lat_data <= hpb_pkg::MEM_RESET;
    end else if (selected && (state == hpb_pkg::HPB_IDLE)) begin
      lat_data <= i_data;
    end
  end

  // data-strobe style: direction sampled at the falling strobe
  logic ds_is_write;
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      ds_is_write <= 1'b0;
    end else if (ds_style && selected && ds_fall) begin
      ds_is_write <= !i_write_or_direction_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write commit
  // separate style stores at the rising write strobe; data-strobe style at the strobe's end
  assign sep_commit  = sep_style && wr_rise;
  assign ds_commit   = ds_style && ds_rise && ds_is_write;
  assign sync_commit = sync_style && (state == hpb_pkg::HPB_WRITE);
  // nothing is stored without chip select, whatever the strobes do
  assign do_write    = selected && (sep_commit || ds_commit || sync_commit);

  assign mem_bus.wr_en   = do_write;
  assign mem_bus.addr    = sync_style ? lat_addr : i_addr;
  assign mem_bus.wr_data = lat_data;

  ////////////////////////////////////////////////////////////////////////
  // data bus drive
  // async styles reach stored data two clocks late; hosts must allow that read access time
  assign sep_drive  = sep_style && !i_read_or_datastrobe_pin;
  assign ds_drive   = ds_style && !i_read_or_datastrobe_pin && i_write_or_direction_pin;
  // sync read data stand from the done state until the host lifts its strobe
  assign sync_drive = sync_style && (state == hpb_pkg::HPB_DONE) && sync_is_read
                      && !i_read_or_datastrobe_pin;
  assign read_phase = selected && (sep_drive || ds_drive || sync_drive);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_data    <= hpb_pkg::MEM_RESET;
    end else begin
      o_data    <= mem_bus.rd_data;
    end
  end

  // the enable alone decides what the host sees; the data register follows the store every clock
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_data_oe <= 1'b0;
    end else begin
      o_data_oe <= read_phase;
    end
  end

  // input buffers open while a write strobe is low in the separate style
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_data_buffer_enable <= 1'b0;
    end else begin
      o_data_buffer_enable <= selected && sep_style && !i_write_or_direction_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronous acknowledge
  // stands in the done state only while the strobe is still held
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_access_ack_out <= 1'b0;
    end else begin
      o_access_ack_out <= (state == hpb_pkg::HPB_DONE) && selected && !i_read_or_datastrobe_pin;
    end
  end
endmodule
`default_nettype wire

// ===== dv/hpb_port_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module hpb_port_monitor (
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  input wire logic [2:0] i_bus_style_select,
  input wire logic       i_chip_select_n,
  input wire logic       i_write_or_direction_pin,
  input wire logic       i_read_or_datastrobe_pin,
  input wire logic       o_data_oe,
  input wire logic       o_data_buffer_enable,
  input wire logic       o_access_ack_out
);
  wire sel = !i_chip_select_n;
  wire s0  = i_bus_style_select == 3'h0;
  wire s1  = i_bus_style_select == 3'h1;
  wire wr  = i_write_or_direction_pin;
  wire rd  = i_read_or_datastrobe_pin;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  cs_idle_a: assert property ($past(i_chip_select_n) |-> !o_data_oe && !o_access_ack_out)
    else $error("drive unselected");
  wr_buf_a: assert property (sel && s0 && !wr |=> o_data_buffer_enable) else $error("buffer off");
  wr_off_a: assert property (wr |=> !o_data_buffer_enable) else $error("buffer stuck");
  rd_drive_a: assert property (sel && s0 && !rd |=> o_data_oe) else $error("read undriven");
  rd_float_a: assert property (s0 && rd |=> !o_data_oe) else $error("not floated");
  ds_read_a: assert property (sel && s1 && !rd && wr |=> o_data_oe) else $error("ds read undriven");
  ds_write_a: assert property (sel && s1 && !wr |=> !o_data_oe) else $error("ds write driven");
  sync_ack_a: assert property (sel && !s0 && !s1 && $fell(rd) |-> ##3 o_access_ack_out)
    else $error("ack late");
  ack_drop_a: assert property (o_access_ack_out && rd |=> !o_access_ack_out) else $error("ack held");
endmodule
`default_nettype wire

// ===== dv/hpb_host.sv
`timescale 1ns/100ps
`default_nettype none
module hpb_host (
  input  wire logic        i_ref_clk,
  input  wire logic        i_ack,
  input  wire logic [7:0]  i_pin,
  output logic      [2:0]  o_sty,
  output logic             o_cs_n,
  output logic      [14:0] o_addr,
  output logic      [7:0]  o_dout,
  output logic             o_den,
  output logic             o_wrp,
  output logic             o_rdp
);
  initial begin
    o_sty = 3'h0;
    o_cs_n = 1'b1;
    o_addr = 15'h0000;
    o_dout = 8'h00;
    o_den = 1'b0;
    o_wrp = 1'b1;
    o_rdp = 1'b1;
  end
  task automatic acc(input logic [2:0] st, input logic sel, input logic wr, input logic [14:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge i_ref_clk);
    o_sty = st;
    o_cs_n = !sel;
    o_addr = a;
    o_dout = d;
    o_den = wr;
    o_wrp = st == 3'h0 ? 1'b1 : st == 3'h1 ? !wr : wr;
    // address and direction settle before the strobe falls
    repeat (2) @(negedge i_ref_clk);
    if (st == 3'h0 && wr) o_wrp = 1'b0;
    else o_rdp = 1'b0;
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (st > 3'h1 ? !i_ack && n < 8 : n < 3);
    q = i_pin;
    if (st == 3'h0) o_wrp = 1'b1;
    o_rdp = 1'b1;
    @(negedge i_ref_clk);
    o_cs_n = 1'b1;
    o_den = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/hpb_port_test.sv
`timescale 1ns/100ps
`default_nettype none
module hpb_port_test;
  logic        clk, srst, cs_n, den, wrp, rdp, oe, be, ack;
  logic [2:0]  sty;
  logic [14:0] adr;
  logic [7:0]  dout, dq, q;
  // an undriven bus shows the inverse of the last byte, never a held value
  wire  [7:0]  pin = oe ? dq : den ? dout : ~dout;
  int          fail_count = 0, checks = 0, cyc = 0;
  hpb_host host (.i_ref_clk(clk), .i_ack(ack), .i_pin(pin), .o_sty(sty), .o_cs_n(cs_n), .o_addr(adr),
                 .o_dout(dout), .o_den(den), .o_wrp(wrp), .o_rdp(rdp));
  hpb_port dut (.i_ref_clk(clk), .i_srst(srst), .i_bus_style_select(sty), .i_chip_select_n(cs_n),
                .i_addr(adr), .i_data(pin), .o_data(dq), .o_data_oe(oe), .o_data_buffer_enable(be),
                .i_write_or_direction_pin(wrp), .i_read_or_datastrobe_pin(rdp), .o_access_ack_out(ack));
  task automatic chk(input string nm, input logic [7:0] e);
    checks++;
    if (q !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, q);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_sep();
    host.acc(3'h0, 1'b1, 1'b1, 15'h7fff, 8'h5a, q);
    host.acc(3'h0, 1'b1, 1'b1, 15'h0000, 8'ha5, q);
    host.acc(3'h0, 1'b0, 1'b1, 15'h0000, 8'h3c, q);
    host.acc(3'h0, 1'b1, 1'b0, 15'h7fff, 8'h00, q);
    chk("sep top", 8'h5a);
    host.acc(3'h0, 1'b1, 1'b0, 15'h0000, 8'h00, q);
    chk("sep unselected", 8'ha5);
    $display("sep test done");
  endtask
  task automatic t_ds();
    host.acc(3'h1, 1'b1, 1'b1, 15'h1234, 8'hc3, q);
    host.acc(3'h1, 1'b1, 1'b0, 15'h1234, 8'h00, q);
    chk("ds byte", 8'hc3);
    host.acc(3'h1, 1'b1, 1'b0, 15'h7fff, 8'h00, q);
    chk("ds other", 8'h5a);
    $display("ds test done");
  endtask
  task automatic t_sync();
    logic [2:0] codes [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    foreach (codes[i]) begin
      host.acc(codes[i], 1'b1, 1'b1, {12'h0a0, codes[i]}, {5'h1b, codes[i]}, q);
      host.acc(codes[i], 1'b1, 1'b0, {12'h0a0, codes[i]}, 8'h00, q);
      chk("sync byte", {5'h1b, codes[i]});
    end
    $display("sync test done");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    srst = 1'b1;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_sep();
    t_ds();
    t_sync();
    wrap_up();
  end
endmodule
bind hpb_port hpb_port_monitor mon (
  .i_ref_clk                (i_ref_clk),
  .i_srst                   (i_srst),
  .i_bus_style_select       (i_bus_style_select),
  .i_chip_select_n          (i_chip_select_n),
  .i_write_or_direction_pin (i_write_or_direction_pin),
  .i_read_or_datastrobe_pin (i_read_or_datastrobe_pin),
  .o_data_oe                (o_data_oe),
  .o_data_buffer_enable     (o_data_buffer_enable),
  .o_access_ack_out         (o_access_ack_out)
);
`default_nettype wire
